// ### rtl/cfr_consts.svh
// Purpose: Constants for the configuration register bank and frame addressing
// Assumes: Included by bare name from the package and the design file
// Notes:   Definitions only
`ifndef CFR_CONSTS_SVH
`define CFR_CONSTS_SVH

// ==========================================================================
// Packet header layout
`define CFR_HDR_TYPE1        3'h1
`define CFR_HDR_TYPE2        3'h2
`define CFR_OP_NOOP          2'h0
`define CFR_OP_READ          2'h1
`define CFR_OP_WRITE         2'h2
`define CFR_T1_CNT_W         11
`define CFR_T2_CNT_W         27

// ==========================================================================
// Register addresses
`define CFR_ADDR_CHECKSUM    5'h00
`define CFR_ADDR_FRAME_ADDR  5'h01
`define CFR_ADDR_FDATA_IN    5'h02
`define CFR_ADDR_FDATA_OUT   5'h03
`define CFR_ADDR_COMMAND     5'h04
`define CFR_ADDR_CTL_PRI     5'h05
`define CFR_ADDR_CTL_MASK    5'h06
`define CFR_ADDR_STATUS      5'h07
`define CFR_ADDR_CHAIN_OUT   5'h08
`define CFR_ADDR_OPT_PRI     5'h09
`define CFR_ADDR_MULTI_FRAME 5'h0A
`define CFR_ADDR_CIPHER_IV   5'h0B
`define CFR_ADDR_IDENTITY    5'h0C
`define CFR_ADDR_USER_ACCESS 5'h0D
`define CFR_ADDR_OPT_SEC     5'h0E
`define CFR_ADDR_WARM_BOOT   5'h10
`define CFR_ADDR_WATCHDOG    5'h11
`define CFR_ADDR_BOOT_HIST   5'h16
`define CFR_ADDR_CTL_SEC     5'h18
`define CFR_ADDR_FLASH_OPT   5'h1F

// ==========================================================================
// Frame geometry, frame address fields, status bit positions and reset word
`define CFR_FRAME_WORDS      7'd123
`define CFR_FRAME_SLOTS      4
`define CFR_FAR_KEEP_A       32'h03FFFFFF
`define CFR_FAR_KEEP_B       32'h07FFFFFF
`define CFR_FAR_STEP_A       32'h00800000
`define CFR_FAR_STEP_B       32'h01000000
`define CFR_BLK_LOGIC        3'h0
`define CFR_BLK_MEMORY       3'h1
`define CFR_STAT_MISMATCH    0
`define CFR_STAT_STARTUP     1
`define CFR_RESET_WORD       32'h00000000

`endif

// ### rtl/cfr_pkg.sv
// Purpose: Shared types of the configuration register bank
// Assumes: cfr_consts.svh on the include path
// Notes:   Numbers live in the header, types here
`include "cfr_consts.svh"
package cfr_pkg;
    typedef logic [31:0] cfr_word_type;
    typedef logic [4:0]  cfr_addr_type;
    typedef logic [26:0] cfr_count_type;
    typedef enum logic [1:0] {CFR_ST_HDR, CFR_ST_WR, CFR_ST_RD, CFR_ST_SKIP} cfr_state_type;
endpackage : cfr_pkg

// ### rtl/cfr_regs.sv
// Purpose: Packet-driven configuration register bank with frame addressing
// Assumes: Packet words arrive from the packet processor on core_clk
// Notes:   Input words pass a 4-word FIFO; reads leave on a valid/ready port
// Notes on behaviour
// - Type 1 header: 001 on top, opcode, low five address bits, 11-bit count.
// - Type 2 header reuses the last Type 1 address with a 27-bit count.
// - Opcode 00 no operation, 01 read, 10 write, 11 reserved.
// - Twenty registers on addresses 00000 to 11111; others unassigned.
// - Matching checksum write clears the mismatch flag and allows start-up.
// - A frame is 123 words of 32 bits; frame boundaries counted so.
// - Frame address takes direct writes and advances once per full frame.
// - First variant: block type 25:23, row 22:17, column 16:7.
// - First variant: frame address bits 31:26 read as zero.
// - Second variant: block type 26:24, row 23:18, column 17:8.
// - Minor field picks a frame in a column: bits 6:0 or 7:0.
// - Block type 000 is logic, I/O and clock; 001 is memory content.
// - Rows count up from the bottom, columns up from zero at the left.
// - Frame input words are stored at the current frame address; the code keeps only four frame slots, picked by its bits 1:0.
// - Frame output reads return frame content from the current frame address; the code reads the slot picked by its bits 1:0.
// - The control write mask is read/write and gates both control writes.
`include "cfr_consts.svh"
`timescale 1ns/100ps
`default_nettype none

// ==========================================================================
// Word FIFO
module cfr_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
) (
    input  wire logic             core_clk,
    input  wire logic             rst_b,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW:0]      wr_ptr_q;
    logic [AW:0]      rd_ptr_q;
    logic             full;
    logic             empty;

    assign empty     = (wr_ptr_q == rd_ptr_q);
    assign full      = (wr_ptr_q[AW] != rd_ptr_q[AW]) && (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem_q[rd_ptr_q[AW-1:0]];

    always_ff @(posedge core_clk)
    begin
        if (in_valid && !full)
        begin
            mem_q[wr_ptr_q[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
        end
        else
        begin
            if (in_valid && !full)
                wr_ptr_q <= wr_ptr_q + 1'b1;
            if (!empty && out_ready)
                rd_ptr_q <= rd_ptr_q + 1'b1;
        end
    end

    default clocking cb_f @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    // A full buffer must refuse the offered word, not overwrite the oldest one
    chk_fifo_full_stall: assert property (full |=> wr_ptr_q == $past(wr_ptr_q))
        else $error("fifo took a word while full");
endmodule : cfr_fifo

// ==========================================================================
// Register bank top
module cfr_regs #(
    parameter bit VARIANT_B = 1'b0
) (
    input  wire logic              core_clk,
    input  wire logic              rst_b,
    input  wire logic              pkt_valid,
    output logic                   pkt_ready,
    input  wire cfr_pkg::cfr_word_type pkt_data,
    output logic                   rd_valid,
    input  wire logic              rd_ready,
    output cfr_pkg::cfr_word_type  rd_data,
    output logic                   checksum_error,
    output logic                   startup_allow,
    output cfr_pkg::cfr_word_type  control_primary,
    output cfr_pkg::cfr_word_type  control_secondary,
    output cfr_pkg::cfr_word_type  command_code
);
    import cfr_pkg::*;

    localparam int MEM_WORDS = `CFR_FRAME_SLOTS * `CFR_FRAME_WORDS;
    localparam cfr_word_type FAR_KEEP = VARIANT_B ? `CFR_FAR_KEEP_B : `CFR_FAR_KEEP_A;
    localparam cfr_word_type FAR_STEP = VARIANT_B ? `CFR_FAR_STEP_B : `CFR_FAR_STEP_A;

    // ======================================================================
    // Input buffering
    logic          in_valid;
    logic          in_take;
    cfr_word_type  in_data;

    cfr_fifo #(.WIDTH(32), .DEPTH(4)) u_fifo (
        .core_clk  (core_clk),
        .rst_b     (rst_b),
        .in_valid  (pkt_valid),
        .in_ready  (pkt_ready),
        .in_data   (pkt_data),
        .out_valid (in_valid),
        .out_ready (in_take),
        .out_data  (in_data)
    );

    // ======================================================================
    // Packet parser
    cfr_state_type state_q;
    cfr_addr_type  addr_q;
    cfr_count_type count_q;
    logic          have_addr_q;
    logic          out_free;
    logic          wr_en;
    logic          rd_en;
    logic [2:0]    hdr_type;
    logic [1:0]    hdr_op;
    cfr_count_type hdr_count;
    logic          hdr_ok;

    assign out_free  = !rd_valid || rd_ready;
    assign hdr_type  = in_data[31:29];
    assign hdr_op    = in_data[28:27];
    assign hdr_ok    = (hdr_type == `CFR_HDR_TYPE1) || (hdr_type == `CFR_HDR_TYPE2 && have_addr_q);
    assign hdr_count = (hdr_type == `CFR_HDR_TYPE1) ? {16'h0000, in_data[10:0]}
                                                    : in_data[26:0];
    assign in_take   = in_valid && (state_q != CFR_ST_RD);
    assign wr_en     = in_valid && (state_q == CFR_ST_WR);
    assign rd_en     = out_free && (state_q == CFR_ST_RD);

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_q     <= CFR_ST_HDR;
            addr_q      <= '0;
            count_q     <= '0;
            have_addr_q <= 1'b0;
        end
        else
        begin
            unique case (state_q)
                CFR_ST_HDR:
                begin
                    if (in_valid && hdr_ok)
                    begin
                        if (hdr_type == `CFR_HDR_TYPE1)
                        begin
                            addr_q      <= in_data[17:13];
                            have_addr_q <= 1'b1;
                        end
                        count_q <= hdr_count;
                        if (hdr_count != '0)
                        begin
                            if (hdr_op == `CFR_OP_WRITE)
                                state_q <= CFR_ST_WR;
                            else if (hdr_op == `CFR_OP_READ)
                                state_q <= CFR_ST_RD;
                            else
                                state_q <= CFR_ST_SKIP;
                        end
                    end
                end
                CFR_ST_WR, CFR_ST_SKIP:
                begin
                    if (in_valid)
                    begin
                        count_q <= count_q - 1'b1;
                        if (count_q == 27'd1)
                            state_q <= CFR_ST_HDR;
                    end
                end
                CFR_ST_RD:
                begin
                    if (out_free)
                    begin
                        count_q <= count_q - 1'b1;
                        if (count_q == 27'd1)
                            state_q <= CFR_ST_HDR;
                    end
                end
            endcase
        end
    end

    // ======================================================================
    // Checksum
    function automatic cfr_word_type crc_step(input cfr_word_type crc, input cfr_addr_type a,
                                              input cfr_word_type d);
        logic [36:0]  bits;
        cfr_word_type c;
        bits = {a, d};
        c    = crc;
        for (int i = 0; i < 37; i++)
        begin
            c = (c[0] ^ bits[i]) ? ((c >> 1) ^ 32'h82F63B78) : (c >> 1);
        end
        return c;
    endfunction : crc_step

    cfr_word_type crc_q;
    logic         checked_q;
    logic         crc_wr;
    logic         crc_match;

    assign crc_wr    = wr_en && (addr_q == `CFR_ADDR_CHECKSUM);
    assign crc_match = (in_data == crc_q);

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            crc_q          <= `CFR_RESET_WORD;
            checksum_error <= 1'b0;
            checked_q      <= 1'b0;
        end
        else if (crc_wr)
        begin
            checksum_error <= !crc_match;
            checked_q      <= 1'b1;
        end
        else if (wr_en)
        begin
            crc_q <= crc_step(crc_q, addr_q, in_data);
        end
    end

    assign startup_allow = checked_q && !checksum_error;

    // ======================================================================
    // Frame address and frame memory
    cfr_word_type frame_addr_q;
    logic [6:0]   word_cnt_q;
    logic         fdi_wr;
    logic         fdo_rd;
    logic         frame_done;
    logic [8:0]   mem_idx;
    cfr_word_type frame_mem_q [MEM_WORDS];
    cfr_word_type far_low_next;

    assign fdi_wr     = wr_en && (addr_q == `CFR_ADDR_FDATA_IN);
    assign fdo_rd     = rd_en && (addr_q == `CFR_ADDR_FDATA_OUT);
    assign frame_done = (fdi_wr || fdo_rd) && (word_cnt_q == `CFR_FRAME_WORDS - 7'd1);
    assign mem_idx    = 9'(frame_addr_q[1:0] * 123) + 9'(word_cnt_q);
    // Row, column and minor form one counter, so a minor wrap carries upward
    assign far_low_next = ((frame_addr_q + 1'b1) & (FAR_STEP - 1'b1))
                        | (frame_addr_q & FAR_KEEP & ~(FAR_STEP - 1'b1));

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            frame_addr_q <= `CFR_RESET_WORD;
            word_cnt_q   <= '0;
        end
        else if (wr_en && addr_q == `CFR_ADDR_FRAME_ADDR)
        begin
            frame_addr_q <= in_data & FAR_KEEP;
            word_cnt_q   <= '0;
        end
        else if (frame_done)
        begin
            frame_addr_q <= far_low_next;
            word_cnt_q   <= '0;
        end
        else if (fdi_wr || fdo_rd)
        begin
            word_cnt_q <= word_cnt_q + 1'b1;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (fdi_wr)
            frame_mem_q[mem_idx] <= in_data;
    end

    // ======================================================================
    // Plain registers and masked control writes
    cfr_word_type gen_q [32];
    cfr_word_type ctl_mask_q;
    logic         gen_wr;

    function automatic logic is_plain(input cfr_addr_type a);
        return a inside {`CFR_ADDR_COMMAND, `CFR_ADDR_CHAIN_OUT, `CFR_ADDR_OPT_PRI,
                         `CFR_ADDR_MULTI_FRAME, `CFR_ADDR_CIPHER_IV, `CFR_ADDR_IDENTITY,
                         `CFR_ADDR_USER_ACCESS, `CFR_ADDR_OPT_SEC, `CFR_ADDR_WARM_BOOT,
                         `CFR_ADDR_WATCHDOG, `CFR_ADDR_FLASH_OPT};
    endfunction : is_plain

    assign gen_wr = wr_en && is_plain(addr_q);

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            for (int i = 0; i < 32; i++)
                gen_q[i] <= `CFR_RESET_WORD;
        end
        else if (gen_wr)
        begin
            gen_q[addr_q] <= in_data;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctl_mask_q        <= `CFR_RESET_WORD;
            control_primary   <= `CFR_RESET_WORD;
            control_secondary <= `CFR_RESET_WORD;
        end
        else if (wr_en)
        begin
            if (addr_q == `CFR_ADDR_CTL_MASK)
                ctl_mask_q <= in_data;
            if (addr_q == `CFR_ADDR_CTL_PRI)
                control_primary <= (control_primary & ~ctl_mask_q) | (in_data & ctl_mask_q);
            if (addr_q == `CFR_ADDR_CTL_SEC)
                control_secondary <= (control_secondary & ~ctl_mask_q) | (in_data & ctl_mask_q);
        end
    end

    assign command_code = gen_q[`CFR_ADDR_COMMAND];

    // ======================================================================
    // Read path
    cfr_word_type rd_word;

    always_comb
    begin
        rd_word = '0;  // write-only and unassigned addresses read zero
        unique case (addr_q)
            `CFR_ADDR_CHECKSUM:   rd_word = crc_q;
            `CFR_ADDR_FRAME_ADDR: rd_word = frame_addr_q;
            `CFR_ADDR_FDATA_OUT:  rd_word = frame_mem_q[mem_idx];
            `CFR_ADDR_CTL_PRI:    rd_word = control_primary;
            `CFR_ADDR_CTL_MASK:   rd_word = ctl_mask_q;
            `CFR_ADDR_CTL_SEC:    rd_word = control_secondary;
            `CFR_ADDR_STATUS:
            begin
                rd_word[`CFR_STAT_MISMATCH] = checksum_error;
                rd_word[`CFR_STAT_STARTUP]  = startup_allow;
            end
            `CFR_ADDR_COMMAND, `CFR_ADDR_OPT_PRI, `CFR_ADDR_IDENTITY, `CFR_ADDR_USER_ACCESS,
            `CFR_ADDR_OPT_SEC, `CFR_ADDR_WARM_BOOT, `CFR_ADDR_WATCHDOG, `CFR_ADDR_FLASH_OPT:
                rd_word = gen_q[addr_q];
            default:              rd_word = '0;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rd_valid <= 1'b0;
            rd_data  <= `CFR_RESET_WORD;
        end
        else if (rd_en)
        begin
            rd_valid <= 1'b1;
            rd_data  <= rd_word;
        end
        else if (rd_ready)
        begin
            rd_valid <= 1'b0;
        end
    end

    // ======================================================================
    // Checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    sequence s_last_frame_word;
        fdi_wr && (word_cnt_q == 7'd122) && !(wr_en && addr_q == `CFR_ADDR_FRAME_ADDR);
    endsequence

    chk_far_auto_step: assert property (s_last_frame_word
                                        |=> (frame_addr_q == $past(far_low_next)) && word_cnt_q == 7'd0)
        else $error("frame address did not advance after a full frame");
    chk_word_count_bound: assert property (word_cnt_q <= 7'd122)
        else $error("frame word counter passed 122");
    chk_far_reserved_zero: assert property ((frame_addr_q & ~FAR_KEEP) == 32'h00000000)
        else $error("reserved frame address bits set");
    chk_crc_match_clear: assert property (crc_wr && crc_match |=> !checksum_error && startup_allow)
        else $error("matching checksum did not clear the mismatch flag");
    chk_crc_miss_set: assert property (crc_wr && !crc_match |=> checksum_error && !startup_allow)
        else $error("mismatching checksum left flag clear");
    chk_mask_hold_bits: assert property (wr_en && addr_q == `CFR_ADDR_CTL_PRI |=>
                                         ((control_primary ^ $past(control_primary))
                                          & ~$past(ctl_mask_q)) == 32'h00000000)
        else $error("control bit changed outside the mask");
    chk_wo_read_zero: assert property (rd_en && addr_q inside {`CFR_ADDR_FDATA_IN, `CFR_ADDR_CHAIN_OUT, 5'h0F}
                                       |=> rd_valid && rd_data == 32'h00000000)
        else $error("write-only or unassigned read returned data");
    chk_ro_write_inert: assert property (wr_en && addr_q == `CFR_ADDR_FDATA_OUT |=> $stable(frame_addr_q))
        else $error("write to read-only port changed state");
    chk_type1_addr: assert property (state_q == CFR_ST_HDR && in_valid && hdr_type == `CFR_HDR_TYPE1
                                     |=> addr_q == $past(in_data[17:13]))
        else $error("type 1 address not latched");
    chk_type2_reuse: assert property (state_q == CFR_ST_HDR && in_valid && hdr_type == `CFR_HDR_TYPE2
                                      |=> $stable(addr_q))
        else $error("type 2 header changed the address");
    chk_read_stall: assert property (rd_valid && !rd_ready |=> rd_valid && $stable(rd_data))
        else $error("read word dropped under back-pressure");
endmodule : cfr_regs

`default_nettype wire

// ### dv/cfr_pkt_proc.sv
// Purpose: Packet processor model that feeds the register bank and takes its read words
// Assumes: The bench queues words through tx_q and pops read words from rx_q
// Notes:   While slow is high rd_ready drops every other cycle to stall the bank
`timescale 1ns/100ps
`default_nettype none

// ==========================================================================
// Packet source and read sink
module cfr_pkt_proc (
    input  wire logic                  core_clk,
    input  wire logic                  rst_b,
    input  wire logic                  slow,
    output logic                       pkt_valid,
    input  wire logic                  pkt_ready,
    output cfr_pkg::cfr_word_type      pkt_data,
    input  wire logic                  rd_valid,
    output logic                       rd_ready,
    input  wire cfr_pkg::cfr_word_type rd_data
);
    import cfr_pkg::*;
    cfr_word_type tx_q[$];
    cfr_word_type rx_q[$];

    // A word stays offered until taken; an idle bus toggles so stale data never passes
    always @(posedge core_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pkt_valid <= 1'b0;
            pkt_data  <= 32'h00000000;
            rd_ready  <= 1'b1;
        end
        else
        begin
            if (pkt_valid && pkt_ready)
                void'(tx_q.pop_front());
            pkt_valid <= (tx_q.size() != 0);
            pkt_data  <= (tx_q.size() != 0) ? tx_q[0] : ~pkt_data;
            if (rd_valid && rd_ready)
                rx_q.push_back(rd_data);
            rd_ready  <= slow ? ~rd_ready : 1'b1;
        end
    end
endmodule : cfr_pkt_proc

`default_nettype wire

// ### dv/cfr_regs_tb_top.sv
// Purpose: Self-checking bench for the configuration register bank
// Assumes: First frame-address layout; packet model in cfr_pkt_proc
// Notes:   Checksum is only matched against its reset value, so no checksum model is kept
`include "cfr_consts.svh"
`timescale 1ns/100ps
`default_nettype none

// ==========================================================================
// Bench top
module cfr_regs_tb_top;
    import cfr_pkg::*;
    logic         core_clk;
    logic         rst_b;
    logic         slow;
    logic         pkt_valid;
    logic         pkt_ready;
    cfr_word_type pkt_data;
    logic         rd_valid;
    logic         rd_ready;
    cfr_word_type rd_data;
    logic         checksum_error;
    logic         startup_allow;
    cfr_word_type control_primary;
    cfr_word_type control_secondary;
    cfr_word_type command_code;
    logic         saw_full = 1'b0;
    int           n_fail;
    int           check_count;
    int           cycles = 0;
    cfr_addr_type rw_list[8] = '{5'h04, 5'h09, 5'h0C, 5'h0D, 5'h0E, 5'h10, 5'h11, 5'h1F};
    cfr_addr_type zero_list[7] = '{5'h02, 5'h08, 5'h0A, 5'h0B, 5'h0F, 5'h12, 5'h16};

    cfr_regs #(.VARIANT_B(1'b0)) cfr_regs_i (.core_clk(core_clk), .rst_b(rst_b), .pkt_valid(pkt_valid),
        .pkt_ready(pkt_ready), .pkt_data(pkt_data), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
        .checksum_error(checksum_error), .startup_allow(startup_allow), .control_primary(control_primary),
        .control_secondary(control_secondary), .command_code(command_code));
    cfr_pkt_proc cfr_pkt_proc_i (.core_clk(core_clk), .rst_b(rst_b), .slow(slow), .pkt_valid(pkt_valid),
        .pkt_ready(pkt_ready), .pkt_data(pkt_data), .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data));

    // ==========================================================================
    // Clock, hang guard and FIFO-full watch
    initial
    begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        if (!pkt_ready)
            saw_full <= 1'b1;
        if (cycles >= 20000)
        begin
            n_fail++;
            report_and_stop();
        end
    end

    // ==========================================================================
    // Tasks
    function automatic cfr_word_type hdr1(input logic [1:0] op, input cfr_addr_type a, input logic [10:0] n);
        return {`CFR_HDR_TYPE1, op, 9'h000, a, 2'h0, n};
    endfunction : hdr1

    task automatic check(input cfr_word_type got, input cfr_word_type exp);
        check_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[FAIL] %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : check

    task automatic send(input cfr_word_type w);
        @(negedge core_clk);
        cfr_pkt_proc_i.tx_q.push_back(w);
    endtask : send

    task automatic wr(input cfr_addr_type a, input cfr_word_type d);
        send(hdr1(`CFR_OP_WRITE, a, 11'h001));
        send(d);
    endtask : wr

    task automatic collect(input int n);
        for (int i = 0; i < 4000 && cfr_pkt_proc_i.rx_q.size() < n; i++)
            @(posedge core_clk);
        if (cfr_pkt_proc_i.rx_q.size() < n)
        begin
            n_fail++;
            $display("[FAIL] %0t ns: read words missing", $time);
        end
    endtask : collect

    task automatic rdchk(input cfr_addr_type a, input cfr_word_type exp);
        send(hdr1(`CFR_OP_READ, a, 11'h001));
        collect(1);
        check(cfr_pkt_proc_i.rx_q.pop_front(), exp);
    endtask : rdchk

    // One whole frame through a zero-count header and a long follow-on header
    task automatic frame_wr();
        send(hdr1(`CFR_OP_WRITE, `CFR_ADDR_FDATA_IN, 11'h000));
        send({`CFR_HDR_TYPE2, `CFR_OP_WRITE, 27'h000007B});
        for (int i = 0; i < 123; i++)
            send(32'hC0DE0000 + 32'(i));
    endtask : frame_wr

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : report_and_stop

    // ==========================================================================
    // Main sequence
    initial
    begin
        rst_b = 1'b0;
        slow = 1'b0;
        n_fail = 0;
        check_count = 0;
        repeat (2) @(posedge core_clk);
        rst_b <= 1'b1;
        rdchk(`CFR_ADDR_STATUS, 32'h00000000);
        wr(`CFR_ADDR_CHECKSUM, 32'hDEADBEEF);
        rdchk(`CFR_ADDR_STATUS, 32'h00000001);
        check({31'h0, checksum_error}, 32'h00000001);
        // Nothing has been summed yet, so zero is the matching value
        wr(`CFR_ADDR_CHECKSUM, 32'h00000000);
        rdchk(`CFR_ADDR_STATUS, 32'h00000002);
        check({30'h0, startup_allow, checksum_error}, 32'h00000002);
        foreach (rw_list[i]) wr(rw_list[i], 32'hA5000000 + 32'(rw_list[i]));
        foreach (rw_list[i]) rdchk(rw_list[i], 32'hA5000000 + 32'(rw_list[i]));
        check(command_code, 32'hA5000004);
        wr(`CFR_ADDR_STATUS, 32'hFFFFFFFF);
        wr(`CFR_ADDR_FDATA_OUT, 32'hFFFFFFFF);
        rdchk(`CFR_ADDR_STATUS, 32'h00000002);
        foreach (zero_list[i]) rdchk(zero_list[i], 32'h00000000);
        wr(`CFR_ADDR_CTL_MASK, 32'h00000100);
        wr(`CFR_ADDR_CTL_PRI, 32'h00000501);
        wr(`CFR_ADDR_CTL_SEC, 32'hFFFFFFFF);
        rdchk(`CFR_ADDR_CTL_MASK, 32'h00000100);
        check(control_primary, 32'h00000100);
        check(control_secondary, 32'h00000100);
        wr(`CFR_ADDR_FRAME_ADDR, 32'hFFFFFFFF);
        rdchk(`CFR_ADDR_FRAME_ADDR, 32'h03FFFFFF);
        send({`CFR_HDR_TYPE1, `CFR_OP_WRITE, 9'h1FF, `CFR_ADDR_FRAME_ADDR, 2'h0, 11'h001});
        send(32'h00000000);
        send(hdr1(2'h3, `CFR_ADDR_FRAME_ADDR, 11'h001));
        send(32'h00000055);
        send(hdr1(`CFR_OP_NOOP, `CFR_ADDR_FRAME_ADDR, 11'h001));
        send(32'h00000066);
        rdchk(`CFR_ADDR_FRAME_ADDR, 32'h00000000);
        frame_wr();
        rdchk(`CFR_ADDR_FRAME_ADDR, 32'h00000001);
        wr(`CFR_ADDR_FRAME_ADDR, {6'h00, 3'h1, 6'h02, 10'h3FF, 7'h7F});
        frame_wr();
        rdchk(`CFR_ADDR_FRAME_ADDR, {6'h00, 3'h1, 6'h03, 10'h000, 7'h00});
        wr(`CFR_ADDR_FRAME_ADDR, 32'h00000000);
        // Stalled readback with words queued behind it fills the input FIFO
        slow <= 1'b1;
        send(hdr1(`CFR_OP_READ, `CFR_ADDR_FDATA_OUT, 11'h07B));
        repeat (6) send(32'h20000000);
        collect(123);
        for (int i = 0; i < 123; i++)
            check(cfr_pkt_proc_i.rx_q.pop_front(), 32'hC0DE0000 + 32'(i));
        slow <= 1'b0;
        rdchk(`CFR_ADDR_FRAME_ADDR, 32'h00000001);
        check({31'h0, saw_full}, 32'h00000001);
        report_and_stop();
    end
endmodule : cfr_regs_tb_top

`default_nettype wire
